// File: src/fpws_cfg.svh
// Offsets, field positions, reset values and timing counts of the flash write sequencer
`ifndef FPWS_CFG_SVH
`define FPWS_CFG_SVH

// ====================================================================
// Register offsets
`define FPWS_OFS_CTRL 8'h00
`define FPWS_OFS_UNLOCK 8'h01
`define FPWS_OFS_LATCH 8'h02
`define FPWS_OFS_PTR_L 8'h03
`define FPWS_OFS_PTR_H 8'h04
`define FPWS_OFS_PTR_U 8'h05
`define FPWS_OFS_STORE 8'h06

// ====================================================================
// Control and store register fields
`define FPWS_CTRL_GO 1
`define FPWS_CTRL_WRITE_ENABLE_BIT 2
`define FPWS_CTRL_ERR 3
`define FPWS_CTRL_WORD_PROGRAM_SELECT 5
`define FPWS_STORE_INC 0

// ====================================================================
// Unlock keys, holding buffer, reset values, pointer width
`define FPWS_KEY_FIRST 8'h55
`define FPWS_KEY_SECOND 8'hAA
`define FPWS_HOLD_BYTES 64
`define FPWS_IDX_W 6
`define FPWS_HOLD_RST 8'hFF
`define FPWS_PTR_W 22

// ====================================================================
// Timing
`define FPWS_CLK_MHZ 250
`define FPWS_LONG_PROG_NS 1000000
`define FPWS_LONG_PROG_CYC ((`FPWS_LONG_PROG_NS * `FPWS_CLK_MHZ) / 1000)

`endif

// File: src/fpws_pkg.sv
// Types shared by the flash write sequencer modules
package fpws_pkg;

  // ====================================================================
  // Sequencer and unlock states
  typedef enum logic {
    FPWS_IDLE,
    FPWS_PROG
  } fpws_state_t;

  typedef enum logic [1:0] {
    FPWS_UNL_NONE,
    FPWS_UNL_FIRST,
    FPWS_UNL_DONE
  } fpws_unl_t;

endpackage : fpws_pkg

// File: src/fpws_seq_if.sv
// Interface joining the sequencer to its holding buffer and programming timer
`timescale 1ns/1ps
`include "fpws_cfg.svh"

interface fpws_seq_if;
  logic hold_wr;
  logic [`FPWS_IDX_W-1:0] hold_wr_idx;
  logic [7:0] hold_wr_data;
  logic [`FPWS_IDX_W-1:0] hold_rd_idx;
  logic [7:0] hold_rd_data;
  logic tmr_start;
  logic tmr_done;

  modport ctrl (
    output hold_wr, hold_wr_idx, hold_wr_data, hold_rd_idx, tmr_start,
    input hold_rd_data, tmr_done
  );
  modport hold (
    input hold_wr, hold_wr_idx, hold_wr_data, hold_rd_idx,
    output hold_rd_data
  );
  modport tmr (
    input tmr_start,
    output tmr_done
  );
endinterface : fpws_seq_if

// File: src/fpws_hold_buf.sv
// Byte-wide holding registers that collect one programming block
`timescale 1ns/1ps
`include "fpws_cfg.svh"

module fpws_hold_buf import fpws_pkg::*; (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Sequencer side
  fpws_seq_if.hold seq
);

  logic [7:0] mem_q [`FPWS_HOLD_BYTES];

  // ====================================================================
  // Storage; contents survive a long write and are only reset with the device
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      for (int i = 0; i < `FPWS_HOLD_BYTES; i++) begin
        mem_q[i] <= `FPWS_HOLD_RST;
      end
    end else if (seq.hold_wr) begin
      mem_q[seq.hold_wr_idx] <= seq.hold_wr_data;
    end
  end

  assign seq.hold_rd_data = mem_q[seq.hold_rd_idx];

endmodule : fpws_hold_buf

// File: src/fpws_prog_timer.sv
// Programming timer that sets the length of a long write
`timescale 1ns/1ps
`include "fpws_cfg.svh"

module fpws_prog_timer import fpws_pkg::*; #(
  parameter int unsigned CYCLES = `FPWS_LONG_PROG_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Sequencer side
  fpws_seq_if.tmr seq
);

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);

  logic [CNT_W-1:0] cnt_q;
  logic run_q;
  logic done_q;

  generate
    if (CYCLES < 2) begin : g_bad
      $error("fpws_prog_timer: CYCLES must be at least 2");
    end
  endgenerate

  // ====================================================================
  // Count down; done pulses for one cycle at the end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (seq.tmr_start) begin
        cnt_q <= CNT_W'(CYCLES - 2);
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == '0) begin
          run_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

  assign seq.tmr_done = done_q;

endmodule : fpws_prog_timer

// File: src/fpws_top.sv
// Flash program write sequencer: table writes, unlock, long write and stall
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "fpws_cfg.svh"

module fpws_top import fpws_pkg::*; #(
  parameter int unsigned PTR_W = `FPWS_PTR_W,
  parameter int unsigned PROG_CYCLES = `FPWS_LONG_PROG_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Core stall
  output logic cpu_stall_out,
  // Flash array write port
  output logic flash_wr_en_out,
  output logic [PTR_W-1:0] flash_addr_out,
  output logic [7:0] flash_data_out
);

  localparam int unsigned IW = `FPWS_IDX_W;

  generate
    // Pointer bytes L and H always exist; U supplies whatever lies above bit 15
    if (PTR_W < 16 || PTR_W > 24) begin : g_bad_ptr
      $error("fpws_top: PTR_W must lie between 16 and 24");
    end
    if (`FPWS_HOLD_BYTES != (1 << IW)) begin : g_bad_idx
      $error("fpws_top: holding index width must address every holding register");
    end
    if (PROG_CYCLES < `FPWS_HOLD_BYTES + 2) begin : g_bad_cyc
      $error("fpws_top: PROG_CYCLES must cover the block transfer");
    end
  endgenerate

  fpws_seq_if seq ();

  fpws_hold_buf u_hold (
    .clk_sys_in (clk_sys_in),
    .reset_in (reset_in),
    .seq (seq.hold)
  );

  fpws_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_tmr (
    .clk_sys_in (clk_sys_in),
    .reset_in (reset_in),
    .seq (seq.tmr)
  );

  // ====================================================================
  // State
  fpws_state_t state_q;
  fpws_unl_t unl_q;
  logic [PTR_W-1:0] ptr_q;
  logic [7:0] latch_q;
  logic write_enable_bit_q;
  logic word_program_select_q;
  logic err_q;
  logic [PTR_W-IW-1:0] blk_q;
  logic [IW-1:0] strm_idx_q;
  logic [IW-1:0] strm_last_q;
  logic strm_act_q;
  logic tmr_start_q;
  logic [7:0] rdata_q;
  logic stall_q;
  logic fwr_q;
  logic [PTR_W-1:0] faddr_q;
  logic [7:0] fdata_q;

  // ====================================================================
  // Decode; registers are frozen while a long write runs
  logic idle;
  logic wr_ctrl;
  logic wr_store;
  logic go_req;
  logic go_ok;
  logic [PTR_W-1:0] ptr_inc;
  logic [23:0] ptr_wide;
  logic wr_latch;
  logic [7:0] ctrl_rd;

  assign idle = (state_q == FPWS_IDLE);
  assign wr_latch = reg_wr_in && idle && (reg_addr_in == `FPWS_OFS_LATCH);
  assign wr_ctrl = reg_wr_in && idle && (reg_addr_in == `FPWS_OFS_CTRL);
  assign wr_store = reg_wr_in && idle && (reg_addr_in == `FPWS_OFS_STORE);
  assign go_req = wr_ctrl && reg_wdata_in[`FPWS_CTRL_GO];
  // Write enable must already be set and stay set in the go write
  assign go_ok = go_req && write_enable_bit_q && reg_wdata_in[`FPWS_CTRL_WRITE_ENABLE_BIT]
    && (unl_q == FPWS_UNL_DONE);
  assign ptr_inc = ptr_q + 1'b1;
  assign ptr_wide = 24'(ptr_q);

  // ====================================================================
  // Unlock sequence: any other write in between breaks it
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      unl_q <= FPWS_UNL_NONE;
    end else if (reg_wr_in && idle) begin
      if (reg_addr_in == `FPWS_OFS_UNLOCK && reg_wdata_in == `FPWS_KEY_FIRST) begin
        unl_q <= FPWS_UNL_FIRST;
      end else if (reg_addr_in == `FPWS_OFS_UNLOCK && reg_wdata_in == `FPWS_KEY_SECOND
                   && unl_q == FPWS_UNL_FIRST) begin
        unl_q <= FPWS_UNL_DONE;
      end else begin
        unl_q <= FPWS_UNL_NONE;
      end
    end
  end

  // ====================================================================
  // Table latch; one byte per table store
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      latch_q <= 8'h00;
    end else if (wr_latch) begin
      latch_q <= reg_wdata_in;
    end
  end

  // ====================================================================
  // Table pointer and holding register stores
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ptr_q <= '0;
    end else if (reg_wr_in && idle) begin
      case (reg_addr_in)
        `FPWS_OFS_PTR_L: ptr_q[7:0] <= reg_wdata_in;
        `FPWS_OFS_PTR_H: ptr_q[15:8] <= 8'(reg_wdata_in);
        `FPWS_OFS_PTR_U: ptr_q <= PTR_W'({reg_wdata_in, ptr_q[15:0]});
        `FPWS_OFS_STORE: begin
          if (reg_wdata_in[`FPWS_STORE_INC]) begin
            ptr_q <= ptr_inc;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Short write: only the holding register at the pointer is touched
  assign seq.hold_wr = wr_store;
  assign seq.hold_wr_idx = reg_wdata_in[`FPWS_STORE_INC] ? ptr_inc[IW-1:0]
                                                        : ptr_q[IW-1:0];
  assign seq.hold_wr_data = latch_q;
  assign seq.hold_rd_idx = strm_idx_q;
  assign seq.tmr_start = tmr_start_q;

  // ====================================================================
  // Control bits
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      write_enable_bit_q <= 1'b0;
      word_program_select_q <= 1'b0;
    end else if (wr_ctrl) begin
      write_enable_bit_q <= reg_wdata_in[`FPWS_CTRL_WRITE_ENABLE_BIT];
      word_program_select_q <= reg_wdata_in[`FPWS_CTRL_WORD_PROGRAM_SELECT];
    end
  end

  // A refused go sets the error flag, which wins over a clear in the same write
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      err_q <= 1'b0;
    end else if (wr_ctrl) begin
      err_q <= (go_req && !go_ok) || (err_q && reg_wdata_in[`FPWS_CTRL_ERR]);
    end
  end

  // Control register as software reads it; unused bits read as zero
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`FPWS_CTRL_GO] = !idle;
    ctrl_rd[`FPWS_CTRL_WRITE_ENABLE_BIT] = write_enable_bit_q;
    ctrl_rd[`FPWS_CTRL_ERR] = err_q;
    ctrl_rd[`FPWS_CTRL_WORD_PROGRAM_SELECT] = word_program_select_q;
  end

  // ====================================================================
  // Long write sequencing
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= FPWS_IDLE;
      blk_q <= '0;
      tmr_start_q <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      tmr_start_q <= 1'b0;
      case (state_q)
        FPWS_IDLE: begin
          if (go_ok) begin
            state_q <= FPWS_PROG;
            blk_q <= ptr_q[PTR_W-1:IW];
            tmr_start_q <= 1'b1;
            stall_q <= 1'b1;
          end
        end
        FPWS_PROG: begin
          // Only the timer ends the write; software cannot cut it short
          if (seq.tmr_done) begin
            state_q <= FPWS_IDLE;
            stall_q <= 1'b0;
          end
        end
        default: begin
          state_q <= FPWS_IDLE;
          stall_q <= 1'b0;
        end
      endcase
    end
  end

  // ====================================================================
  // Byte stream index; word mode sends only the addressed word
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      strm_idx_q <= '0;
      strm_last_q <= '0;
      strm_act_q <= 1'b0;
    end else if (go_ok) begin
      strm_act_q <= 1'b1;
      if (word_program_select_q) begin
        strm_idx_q <= {ptr_q[IW-1:1], 1'b0};
        strm_last_q <= {ptr_q[IW-1:1], 1'b1};
      end else begin
        strm_idx_q <= '0;
        strm_last_q <= IW'(`FPWS_HOLD_BYTES - 1);
      end
    end else if (strm_act_q && !idle) begin
      strm_idx_q <= strm_idx_q + 1'b1;
      if (strm_idx_q == strm_last_q) begin
        strm_act_q <= 1'b0;
      end
    end
  end

  // ====================================================================
  // Holding register contents stream to the array, one byte per cycle
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      fwr_q <= 1'b0;
      faddr_q <= '0;
      fdata_q <= 8'h00;
    end else begin
      fwr_q <= strm_act_q;
      faddr_q <= {blk_q, strm_idx_q};
      fdata_q <= seq.hold_rd_data;
    end
  end

  // ====================================================================
  // Read port; data stands in the cycle after the strobe only
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `FPWS_OFS_CTRL: rdata_q <= ctrl_rd;
        `FPWS_OFS_LATCH: rdata_q <= latch_q;
        `FPWS_OFS_PTR_L: rdata_q <= ptr_wide[7:0];
        `FPWS_OFS_PTR_H: rdata_q <= ptr_wide[15:8];
        `FPWS_OFS_PTR_U: rdata_q <= ptr_wide[23:16];
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign cpu_stall_out = stall_q;
  assign flash_wr_en_out = fwr_q;
  assign flash_addr_out = faddr_q;
  assign flash_data_out = fdata_q;

endmodule : fpws_top

// File: verif/fpws_top_properties.sv
// Concurrent checks on the flash write sequencer top-level ports
`timescale 1ns/1ps
`include "fpws_cfg.svh"

module fpws_top_properties import fpws_pkg::*; #(
  parameter int unsigned PTR_W = `FPWS_PTR_W,
  parameter int unsigned PROG_CYCLES = `FPWS_LONG_PROG_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Stall and array port
  input wire logic cpu_stall_out,
  input wire logic flash_wr_en_out,
  input wire logic [PTR_W-1:0] flash_addr_out,
  input wire logic [7:0] flash_data_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  logic k1_q;
  logic k2_q;
  logic [31:0] sc_q;
  logic [31:0] pc_q;
  wire go_wr = reg_wr_in && reg_addr_in == `FPWS_OFS_CTRL && reg_wdata_in[`FPWS_CTRL_GO];
  wire unl_wr = reg_wr_in && reg_addr_in == `FPWS_OFS_UNLOCK;

  // ====================================================================
  // Key tracking: keys seen during a stall are kept, so this only errs lenient
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || reg_wr_in) begin
      k1_q <= !reset_in && unl_wr && reg_wdata_in == `FPWS_KEY_FIRST;
      k2_q <= !reset_in && unl_wr && reg_wdata_in == `FPWS_KEY_SECOND && k1_q;
    end
  end

  // ====================================================================
  // Stall length and pulse count of the current long write
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !cpu_stall_out) begin
      sc_q <= 32'h0;
      pc_q <= 32'h0;
    end else begin
      sc_q <= sc_q + 32'h1;
      pc_q <= pc_q + {31'h0, flash_wr_en_out};
    end
  end

  // ====================================================================
  // Properties
  sequence s_start;
    $rose(cpu_stall_out);
  endsequence
  sequence s_first_bytes;
    flash_wr_en_out [*2];
  endsequence

  AST_STALL_CAUSE: assert property (
    s_start |-> $past(go_wr && reg_wdata_in[`FPWS_CTRL_WRITE_ENABLE_BIT]))
    else $error("stall rose without a go write");
  AST_KEYS_NEEDED: assert property (go_wr && !k2_q && !cpu_stall_out |=> !cpu_stall_out)
    else $error("go started without both keys");
  AST_FIRST_BYTES: assert property (s_start |=> s_first_bytes)
    else $error("array writes did not follow the start");
  AST_STALL_LEN: assert property ($fell(cpu_stall_out) |-> sc_q == PROG_CYCLES + 1)
    else $error("stall length wrong");
  AST_WR_IN_STALL: assert property (flash_wr_en_out |-> cpu_stall_out)
    else $error("array write while core runs");
  AST_SHORT_WRITE: assert property (
    reg_wr_in && reg_addr_in == `FPWS_OFS_STORE && !cpu_stall_out |=> !flash_wr_en_out)
    else $error("table store reached the array");
  AST_ADDR_STEP: assert property (
    flash_wr_en_out && $past(flash_wr_en_out)
    |-> flash_addr_out == $past(flash_addr_out) + 1'b1)
    else $error("array address did not step by one");
  AST_PULSE_COUNT: assert property (
    $fell(cpu_stall_out) |-> pc_q == 32'h40 || pc_q == 32'h2)
    else $error("wrong number of array writes");
endmodule : fpws_top_properties

bind fpws_top fpws_top_properties #(.PTR_W(PTR_W), .PROG_CYCLES(PROG_CYCLES)) u_props (
  .clk_sys_in(clk_sys_in),
  .reset_in(reset_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out),
  .cpu_stall_out(cpu_stall_out),
  .flash_wr_en_out(flash_wr_en_out),
  .flash_addr_out(flash_addr_out),
  .flash_data_out(flash_data_out)
);

// File: verif/fpws_flash_model.sv
// Flash array model that records every byte the sequencer programs
`timescale 1ns/1ps

module fpws_flash_model #(
  parameter int unsigned PTR_W = 22
) (
  // Clock
  input wire logic clk_sys_in,
  // Array write port
  input wire logic flash_wr_en_in,
  input wire logic [PTR_W-1:0] flash_addr_in,
  input wire logic [7:0] flash_data_in
);
  logic [7:0] mem [int];
  int wr_cnt = 0;
  int dbl_cnt = 0;

  // ====================================================================
  // Reprogramming a byte without an erase is counted, not silently merged
  always @(posedge clk_sys_in) begin
    if (flash_wr_en_in === 1'b1) begin
      if (mem.exists(int'(flash_addr_in))) dbl_cnt++;
      mem[int'(flash_addr_in)] = flash_data_in;
      wr_cnt++;
    end
  end

  task automatic erase();
    mem.delete();
    wr_cnt = 0;
  endtask : erase
endmodule : fpws_flash_model

// File: verif/flash_program_write_sequencer_tb_top.sv
// Self-checking testbench for the flash write sequencer
`timescale 1ns/1ps
`include "fpws_cfg.svh"

module flash_program_write_sequencer_tb_top;
  // Short long-write time keeps the run brief
  localparam int unsigned PROG = 100;
  localparam int unsigned PW = 22;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] rdata;
  logic stall;
  logic fwe;
  logic [PW-1:0] faddr;
  logic [7:0] fdata;
  int err_total = 0;
  int n_tests = 0;
  int n;

  initial forever #2 clk_sys_in = ~clk_sys_in;

  fpws_top #(.PTR_W(PW), .PROG_CYCLES(PROG)) dut (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd),
    .reg_rdata_out(rdata),
    .cpu_stall_out(stall),
    .flash_wr_en_out(fwe),
    .flash_addr_out(faddr),
    .flash_data_out(fdata)
  );

  fpws_flash_model #(.PTR_W(PW)) mdl (
    .clk_sys_in(clk_sys_in),
    .flash_wr_en_in(fwe),
    .flash_addr_in(faddr),
    .flash_data_in(fdata)
  );

  // ====================================================================
  // Bus tasks and checks
  function automatic logic [7:0] dat(input int i);
    return 8'(i) ^ 8'hA5;
  endfunction : dat

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys_in);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys_in);
    reg_rd <= 1'b0;
    #1;
    chk(what, {24'h0, exp}, {24'h0, rdata});
  endtask : rd

  task automatic start(input logic [7:0] ctrl);
    wr(`FPWS_OFS_UNLOCK, `FPWS_KEY_FIRST);
    wr(`FPWS_OFS_UNLOCK, `FPWS_KEY_SECOND);
    wr(`FPWS_OFS_CTRL, ctrl);
  endtask : start

  task automatic wait_idle();
    n = 0;
    // Look once before the first edge: stall is already up after the go edge
    repeat (400) begin
      #1;
      if (stall === 1'b1) n++;
      else if (n > 0) break;
      @(posedge clk_sys_in);
    end
  endtask : wait_idle

  task automatic stop_test();
    $display("Mismatches %0d of %0d comparisons", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // ====================================================================
  // Test sequence
  initial begin
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd(`FPWS_OFS_CTRL, 8'h00, "ctrl reset");
    rd(`FPWS_OFS_LATCH, 8'h00, "latch reset");
    rd(`FPWS_OFS_UNLOCK, 8'h00, "unlock read");
    rd(8'h7F, 8'h00, "unmapped read");
    // Pointer sits one below the block so each store pre-increments into place
    wr(`FPWS_OFS_PTR_L, 8'hFF);
    wr(`FPWS_OFS_PTR_H, 8'h03);
    wr(`FPWS_OFS_PTR_U, 8'h00);
    for (int i = 0; i < 64; i++) begin
      wr(`FPWS_OFS_LATCH, dat(i));
      wr(`FPWS_OFS_STORE, 8'h01);
    end
    chk("array writes during load", 32'h0, mdl.wr_cnt);
    rd(`FPWS_OFS_LATCH, dat(63), "latch readback");
    wr(`FPWS_OFS_CTRL, 8'h04);
    wr(`FPWS_OFS_CTRL, 8'h06);
    rd(`FPWS_OFS_CTRL, 8'h0C, "go without keys");
    wr(`FPWS_OFS_CTRL, 8'h04);
    wr(`FPWS_OFS_UNLOCK, `FPWS_KEY_SECOND);
    wr(`FPWS_OFS_UNLOCK, `FPWS_KEY_FIRST);
    wr(`FPWS_OFS_CTRL, 8'h06);
    rd(`FPWS_OFS_CTRL, 8'h0C, "keys reversed");
    wr(`FPWS_OFS_CTRL, 8'h04);
    start(8'h06);
    wait_idle();
    chk("stall cycles", PROG + 1, n);
    for (int i = 0; i < 64; i++) chk("block byte", dat(i), mdl.mem[32'h400 + i]);
    rd(`FPWS_OFS_CTRL, 8'h04, "ctrl after write");
    mdl.erase();
    wr(`FPWS_OFS_CTRL, 8'h24);
    start(8'h26);
    wr(`FPWS_OFS_LATCH, 8'h11);
    wait_idle();
    chk("word mode writes", 32'h2, mdl.wr_cnt);
    chk("word low byte", dat(62), mdl.mem[32'h43E]);
    chk("word high byte", dat(63), mdl.mem[32'h43F]);
    chk("double programs", 32'h0, mdl.dbl_cnt);
    rd(`FPWS_OFS_LATCH, dat(63), "latch after stalled write");
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge clk_sys_in);
    err_total++;
    stop_test();
  end
endmodule : flash_program_write_sequencer_tb_top
